// *** rtl/sio_clk_div.sv ***
/*
  Half-period tick generator for the internal serial clock.
  Assumes sel 0..6 picks n = sel + 3; the tick comes every 2^n cycles.
*/
`timescale 1ns/1ps
`include "sio_defs.svh"
module sio_clk_div #(
  parameter int CW = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;
  logic [3:0] n;
  logic [CW-1:0] limit;

  // Seven rates, each a power of two of pclk
  always_comb begin
    n = 4'(sel) + `SCK_BASE_N;
    limit = CW'((1 << n) - 1);
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == limit) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : sio_clk_div

// *** rtl/sio_ctrl.sv ***
/*
  Synchronous serial controller: mode select, transfer status, idle run
  control, serial clock sourcing and shift edges, APB register slave and
  interrupt. Assumes an APB master on pclk and a serial partner on the pins.
*/
// Our own choices: the APB slave port and the register offsets.
// Overview of operation
// - The two-bit mode field picks port mode, synchronous serial, two-wire bus or reserved.
// - Mode control and status share one address, written and read differently.
// - In synchronous serial mode the shared address reads ones in bits 7-4 and 1-0, zero above 7.
// - Status bit 3 reads one while a transfer runs and zero once done.
// - Status bit 2 reads one while shifting and zero once shifting is done.
// - Idle control bit 6 stops the interface in idle when zero and keeps it running when one.
// - The clock select field picks an internal or an external serial clock.
// - An internal clock offers seven rates and is driven out on the clock pin.
// - With an internal clock the clock pin is high when a transfer begins.
// - With an internal clock an unserviced buffer stops the clock and holds the next shift.
// - Clock select 111 takes the shift clock from the clock pin.
// - Transmit data change on the falling edge of the serial clock.
// - Receive data are taken on the rising edge of the serial clock.
`timescale 1ns/1ps
`include "sio_defs.svh"
module sio_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_mode,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe,
  output logic irq
);
  import sio_pkg::*;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic [1:0] pins_s;
  logic sck_s;
  logic si_s;
  logic tick;
  logic div_run;
  logic sio_on;
  logic ext;
  logic halt;

  // Pins cross into pclk through two flops
  sio_sync #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({sck_in, si_in}),
    .sync_out(pins_s)
  );
  assign sck_s = pins_s[1];
  assign si_s = pins_s[0];

  // Divider runs only while shifting on the internal clock
  assign sio_on = (s_q.mode == `MODE_SYNC);
  assign ext = (s_q.sck_sel == `SCK_EXTERNAL);
  assign halt = idle_mode & ~s_q.idle_run;
  assign div_run = sio_on & ~ext & ~halt & (s_q.st == ST_SHIFT);

  sio_clk_div #(.CW(10)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(div_run),
    .sel(s_q.sck_sel),
    .tick(tick)
  );

  // Next-state logic: bus access first, then the engine, so hardware sets win
  always_comb begin
    logic acc;
    logic wr;
    logic rd;
    logic need_tx;
    logic need_rx;
    logic serviced;
    logic fall_ev;
    logic rise_ev;
    logic [1:0] int_set;
    logic [1:0] int_clr;
    logic [31:0] rdat;
    logic err;
    logic [7:0] sh_in;
    acc = psel & penable;
    wr = acc & pwrite & s_q.pready;
    rd = acc & ~pwrite & s_q.pready;
    need_tx = (s_q.dir != `DIR_RX);
    need_rx = (s_q.dir != `DIR_TX);
    serviced = 1'b0;
    fall_ev = 1'b0;
    rise_ev = 1'b0;
    int_set = 2'h0;
    int_clr = 2'h0;
    rdat = 32'h00000000;
    err = 1'b0;
    sh_in = 8'h00;
    s_d = s_q;
    s_d.sck_prev = sck_s;

    // Read mux; the shared address returns status, never mode
    unique case (paddr)
      `OFF_XFER_CTRL: begin
        rdat[`XC_START_BIT] = s_q.start;
        rdat[`XC_INH_BIT] = s_q.inh;
        rdat[`XC_MODE_HI:`XC_MODE_LO] = s_q.dir;
        rdat[`XC_ONE_BIT] = 1'b1;
        rdat[`XC_SCK_HI:`XC_SCK_LO] = s_q.sck_sel;
      end
      `OFF_DATA_BUF: rdat[7:0] = s_q.rx_buf;
      `OFF_MODE_STAT: begin
        rdat = sio_on ? `STAT_ONES : 32'h00000000;
        rdat[`ST_ACTIVE_BIT] = (s_q.st != ST_IDLE);
        rdat[`ST_SHIFT_BIT] = (s_q.st == ST_SHIFT);
      end
      `OFF_IDLE_CTRL: begin
        rdat = `IDLE_ONES;
        rdat[`IDLE_RUN_BIT] = s_q.idle_run;
      end
      `OFF_INT_STAT: rdat[1:0] = s_q.int_st;
      `OFF_INT_CLR: rdat = 32'h00000000;
      `OFF_INT_EN: rdat[1:0] = s_q.int_en;
      default: err = 1'b1;
    endcase

    // One wait state: pready rises in the second access cycle
    s_d.pready = acc & ~s_q.pready;
    s_d.pslverr = acc & ~s_q.pready & err;
    if (acc & ~s_q.pready & ~pwrite) begin
      s_d.prdata = rdat;
    end

    if (wr) begin
      unique case (paddr)
        `OFF_XFER_CTRL: begin
          s_d.start = pwdata[`XC_START_BIT];
          s_d.inh = pwdata[`XC_INH_BIT];
          s_d.dir = pwdata[`XC_MODE_HI:`XC_MODE_LO];
          s_d.sck_sel = pwdata[`XC_SCK_HI:`XC_SCK_LO];
        end
        `OFF_DATA_BUF: begin
          s_d.tx_buf = pwdata[7:0];
          s_d.tx_full = 1'b1;
        end
        `OFF_MODE_STAT: s_d.mode = pwdata[`MODE_HI:`MODE_LO];
        `OFF_IDLE_CTRL: s_d.idle_run = pwdata[`IDLE_RUN_BIT];
        `OFF_INT_CLR: int_clr = pwdata[1:0];
        `OFF_INT_EN: s_d.int_en = pwdata[1:0];
        default: begin
        end
      endcase
    end
    if (rd && paddr == `OFF_DATA_BUF) begin
      s_d.rx_full = 1'b0;
    end

    // Shift events: internal ticks or synchronised pin edges, frozen in idle
    if (ext) begin
      fall_ev = s_q.sck_prev & ~sck_s;
      rise_ev = ~s_q.sck_prev & sck_s;
    end else begin
      fall_ev = tick & s_q.sck_o;
      rise_ev = tick & ~s_q.sck_o;
    end
    fall_ev = fall_ev & ~halt;
    rise_ev = rise_ev & ~halt;
    serviced = (~need_tx | s_d.tx_full) & (~need_rx | ~s_d.rx_full);

    unique case (s_q.st)
      ST_IDLE: begin
        s_d.sck_o = 1'b1;
        if (sio_on && s_q.start && !s_q.inh && serviced) begin
          s_d.st = ST_SHIFT;
          s_d.sck_o = 1'b1;
          s_d.bitcnt = 3'h0;
          s_d.sh = need_tx ? s_d.tx_buf : 8'h00;
          s_d.tx_full = s_d.tx_full & ~need_tx;
        end
      end
      ST_SHIFT: begin
        if (!ext && (fall_ev || rise_ev)) begin
          s_d.sck_o = ~s_q.sck_o;
        end
        if (fall_ev && need_tx) begin
          s_d.so_o = s_q.sh[0];
        end
        if (rise_ev) begin
          sh_in = {si_s, s_q.sh[7:1]};
          s_d.sh = sh_in;
          s_d.bitcnt = s_q.bitcnt + 3'h1;
          if (s_q.bitcnt == 3'h7) begin
            int_set[`INT_BYTE] = 1'b1;
            if (need_rx) begin
              s_d.rx_buf = sh_in;
              s_d.rx_full = 1'b1;
            end
            serviced = (~need_tx | s_d.tx_full) & (~need_rx | ~s_d.rx_full);
            if (!s_q.start) begin
              s_d.st = ST_IDLE;
              int_set[`INT_END] = 1'b1;
            end else if (serviced || ext) begin
              s_d.sh = need_tx ? s_d.tx_buf : 8'h00;
              s_d.tx_full = s_d.tx_full & ~need_tx;
            end else begin
              s_d.st = ST_WAIT;
            end
          end
        end
      end
      ST_WAIT: begin
        s_d.sck_o = 1'b1;
        if (!s_q.start) begin
          s_d.st = ST_IDLE;
          int_set[`INT_END] = 1'b1;
        end else if (serviced) begin
          s_d.st = ST_SHIFT;
          s_d.bitcnt = 3'h0;
          s_d.sh = need_tx ? s_d.tx_buf : 8'h00;
          s_d.tx_full = s_d.tx_full & ~need_tx;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // Forced stop or leaving serial mode ends at once, clock parked high
    if (s_q.inh || !sio_on) begin
      s_d.st = ST_IDLE;
      s_d.sck_o = 1'b1;
      if (s_q.st != ST_IDLE) begin
        int_set[`INT_END] = 1'b1;
      end
    end

    // Pin enables are registered from the values written this cycle, so they never lag the mode
    s_d.sck_en = (s_d.mode == `MODE_SYNC) & (s_d.sck_sel != `SCK_EXTERNAL);
    s_d.so_en = (s_d.mode == `MODE_SYNC);

    // Sticky events: a set in the clearing cycle survives
    s_d.int_st = (s_q.int_st & ~int_clr) | int_set;
    s_d.irq = |(s_d.int_st & s_d.int_en);
  end

  // Reset leaves pins as ports and the engine stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.mode <= `RST_MODE;
      s_q.inh <= `RST_XFER_INH;
      s_q.sck_sel <= `RST_SCK_SEL;
      s_q.sck_o <= 1'b1;
      s_q.so_o <= 1'b1;
      s_q.sck_prev <= 1'b1;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Pins and bus outputs straight from the state flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign sck_out = s_q.sck_o;
  assign sck_oe = s_q.sck_en;
  assign so_out = s_q.so_o;
  assign so_oe = s_q.so_en;
  assign irq = s_q.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence status_read_s;
    psel && penable && !pwrite && !s_q.pready && paddr == `OFF_MODE_STAT;
  endsequence

  sequence int_start_s;
    s_q.st == ST_IDLE && !ext ##1 s_q.st == ST_SHIFT;
  endsequence

  mode_gates_engine_a: assert property (!sio_on |=> s_q.st == ST_IDLE)
    else $error("engine active outside serial mode");

  status_ones_a: assert property (status_read_s and sio_on |=>
    prdata[7:4] == 4'hF && prdata[1:0] == 2'h3 && prdata[31:8] == 24'h000000)
    else $error("status constant bits wrong");

  active_flag_a: assert property (status_read_s |=> prdata[3] == ($past(s_q.st) != ST_IDLE))
    else $error("transfer flag mismatch");

  shift_flag_a: assert property (status_read_s |=> prdata[2] == ($past(s_q.st) == ST_SHIFT))
    else $error("shift flag mismatch");

  idle_freeze_a: assert property (halt && s_q.st == ST_SHIFT && !s_q.inh && sio_on
    |=> $stable(s_q.bitcnt) && $stable(s_q.so_o))
    else $error("interface moved while halted in idle");

  start_high_a: assert property (int_start_s |-> sck_out)
    else $error("clock not high at transfer start");

  wait_clock_a: assert property ((s_q.st == ST_WAIT && !ext) [*2] |-> sck_out)
    else $error("clock ran during wait");

  ext_no_drive_a: assert property (sio_on && ext |-> !sck_oe)
    else $error("clock pin driven in external mode");

  out_on_fall_a: assert property (!ext && !$past(ext) && $changed(so_out) |-> $fell(sck_out))
    else $error("data out changed away from falling edge");

  in_on_rise_a: assert property (!ext && !$past(ext) && $past(s_q.st) == ST_SHIFT
    && $changed(s_q.bitcnt) |-> $rose(sck_out))
    else $error("data in taken away from rising edge");
endmodule : sio_ctrl

// *** rtl/sio_defs.svh ***
/*
  Register offsets, field positions, reset values and fixed codes of the
  synchronous serial clock and status controller.
  Assumes a 32-bit APB with byte addresses; every register is one word.
*/
`ifndef SIO_DEFS_SVH
`define SIO_DEFS_SVH

// Register byte offsets
`define OFF_XFER_CTRL 8'h00
`define OFF_DATA_BUF 8'h04
`define OFF_MODE_STAT 8'h08
`define OFF_IDLE_CTRL 8'h0C
`define OFF_INT_STAT 8'h10
`define OFF_INT_CLR 8'h14
`define OFF_INT_EN 8'h18

// Transfer control fields
`define XC_START_BIT 7
`define XC_INH_BIT 6
`define XC_MODE_HI 5
`define XC_MODE_LO 4
`define XC_ONE_BIT 3
`define XC_SCK_HI 2
`define XC_SCK_LO 0

// Interface mode select and codes
`define MODE_HI 3
`define MODE_LO 2
`define MODE_PORT 2'h0
`define MODE_SYNC 2'h1
`define MODE_TWO_WIRE 2'h2

// Status bits and constant ones
`define ST_ACTIVE_BIT 3
`define ST_SHIFT_BIT 2
`define STAT_ONES 32'h000000F3

// Idle run control
`define IDLE_RUN_BIT 6
`define IDLE_ONES 32'h000000BE

// Transfer direction codes
`define DIR_TX 2'h0
`define DIR_TXRX 2'h2
`define DIR_RX 2'h3

// Clock select
`define SCK_EXTERNAL 3'h7
`define SCK_BASE_N 4'h3

// Interrupt bits
`define INT_BYTE 0
`define INT_END 1

// Reset values
`define RST_MODE 2'h0
`define RST_XFER_INH 1'h1
`define RST_SCK_SEL 3'h0

`endif

// *** rtl/sio_pkg.sv ***
/*
  Types of the synchronous serial controller.
  Assumes sio_defs.svh holds all numbers.
*/
package sio_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_WAIT = 2'b10
  } xfer_state_t;

  typedef struct packed {
    logic [1:0] mode;
    logic start;
    logic inh;
    logic [1:0] dir;
    logic [2:0] sck_sel;
    logic idle_run;
    logic [7:0] tx_buf;
    logic tx_full;
    logic [7:0] rx_buf;
    logic rx_full;
    logic [7:0] sh;
    logic [2:0] bitcnt;
    xfer_state_t st;
    logic sck_o;
    logic so_o;
    logic sck_en;
    logic so_en;
    logic sck_prev;
    logic [1:0] int_st;
    logic [1:0] int_en;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctrl_state_t;

endpackage : sio_pkg

// *** rtl/sio_sync.sv ***
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes inputs are asynchronous to pclk.
*/
`timescale 1ns/1ps
module sio_sync #(
  parameter int W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // Idle lines are high, so reset to ones
  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;
endmodule : sio_sync

// *** tb/serial_peer.sv ***
/*
  Far-side serial device: sends a byte LSB first, takes one back, and makes
  the clock when the block runs on an external clock.
  Assumes sck_line is the resolved level of the clock pin.
*/
`timescale 1ns/1ps
module serial_peer (
  input wire logic sck_line,
  input wire logic so_line,
  input wire logic ext_run,
  input wire logic [7:0] tx_byte,
  output logic peer_sck,
  output logic si_line,
  output logic [7:0] rx_byte
);
  logic [2:0] nfall;
  // Clock stands high between frames, 160 ns period while running
  initial begin
    peer_sck = 1'b1;
    nfall = 3'h0;
    si_line = 1'b1;
    rx_byte = 8'h00;
    forever begin
      wait (ext_run);
      #80;
      // No new period once the frame is withdrawn, so the line rests high
      if (ext_run) begin
        peer_sck = 1'b0;
        #80 peer_sck = 1'b1;
      end
    end
  end
  // A new frame starts at bit 0; a released data line shows no stale level
  always @(posedge ext_run) nfall = 3'h0;
  always @(negedge ext_run) si_line <= ~si_line;
  // Bit changes on the fall so it is settled at the rise
  always @(negedge sck_line) begin
    si_line <= tx_byte[nfall];
    nfall <= nfall + 3'h1;
  end
  // Data from the block taken on each rise
  always @(posedge sck_line) rx_byte <= {so_line, rx_byte[7:1]};
endmodule : serial_peer

// *** tb/testbench.sv ***
/*
  Self-checking bench of sio_ctrl: registers over APB, bytes on internal and
  external clock against serial_peer.
  Assumes the offsets and constants of sio_defs.svh.
*/
`timescale 1ns/1ps
`include "sio_defs.svh"
module testbench;
  import sio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, idle_mode;
  logic sck_out, sck_oe, so_out, so_oe, irq, ext_run, peer_sck, si_line, err, sck_line;
  logic [7:0] paddr, peer_tx, peer_rx;
  logic [31:0] pwdata, prdata, rd;
  int num_errors, tests_run;
  // Pin level: the block drives it only while its enable is high
  assign sck_line = sck_oe ? sck_out : peer_sck;

  sio_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idle_mode(idle_mode), .sck_in(sck_line), .sck_out(sck_out),
    .sck_oe(sck_oe), .si_in(si_line), .so_out(so_out), .so_oe(so_oe), .irq(irq));
  serial_peer i_peer (.sck_line(sck_line), .so_line(so_out), .ext_run(ext_run),
    .tx_byte(peer_tx), .peer_sck(peer_sck), .si_line(si_line), .rx_byte(peer_rx));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the wait for pready is cut short only by the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_irq();
    repeat (3000) begin
      @(posedge pclk);
      if (irq === 1'b1) break;
    end
    chk(irq, 1'b1);
  endtask : wait_irq

  // Polls status until the transfer flag drops, bounded
  task automatic wait_done();
    repeat (200) begin
      apb(1'b0, `OFF_MODE_STAT, 32'h0);
      if (rd[`ST_ACTIVE_BIT] === 1'b0) break;
    end
  endtask : wait_done

  task automatic t_reset();
    chk(sck_oe, 1'b0);
    apb(1'b0, `OFF_MODE_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `OFF_XFER_CTRL, 32'h0);
    chk(rd, 32'h48);
    apb(1'b0, 8'h1C, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("reset and unmapped done");
  endtask : t_reset

  task automatic t_modes();
    // Pins must rest high before leaving port mode for the two-wire bus
    chk({sck_line, si_line}, 32'h3);
    for (int m = 3; m >= 0; m--) begin
      apb(1'b1, `OFF_MODE_STAT, m << 2);
      apb(1'b0, `OFF_MODE_STAT, 32'h0);
      chk(rd, (m == 1) ? `STAT_ONES : 32'h0);
      chk({so_oe, sck_oe}, (m == 1) ? 32'h3 : 32'h0);
    end
    apb(1'b1, `OFF_MODE_STAT, 32'h4);
    apb(1'b1, `OFF_IDLE_CTRL, 32'h40);
    apb(1'b0, `OFF_IDLE_CTRL, 32'h0);
    chk(rd, 32'hFE);
    apb(1'b1, `OFF_IDLE_CTRL, 32'h0);
    $display("modes done");
  endtask : t_modes

  // Internal clock, full duplex, then wait state, stop and interrupt
  task automatic t_internal();
    logic held;
    held = 1'b1;
    peer_tx <= 8'h3C;
    apb(1'b1, `OFF_XFER_CTRL, 32'h60);
    apb(1'b1, `OFF_INT_EN, 32'h3);
    apb(1'b1, `OFF_DATA_BUF, 32'hA5);
    apb(1'b1, `OFF_XFER_CTRL, 32'hA0);
    chk(sck_out, 1'b1);
    repeat (30) @(posedge pclk);
    apb(1'b0, `OFF_MODE_STAT, 32'h0);
    chk(rd, 32'hFF);
    wait_irq();
    chk(peer_rx, 8'hA5);
    repeat (80) begin
      @(posedge pclk);
      if (sck_out !== 1'b1) held = 1'b0;
    end
    chk(held, 1'b1);
    apb(1'b0, `OFF_DATA_BUF, 32'h0);
    chk(rd, 32'h3C);
    apb(1'b1, `OFF_XFER_CTRL, 32'h20);
    wait_done();
    chk(rd, `STAT_ONES);
    apb(1'b0, `OFF_INT_STAT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, `OFF_INT_EN, 32'h0);
    @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, `OFF_INT_CLR, 32'h3);
    apb(1'b1, `OFF_INT_EN, 32'h3);
    apb(1'b0, `OFF_INT_STAT, 32'h0);
    chk({irq, rd[30:0]}, 32'h0);
    $display("internal clock done");
  endtask : t_internal

  // Transmit only at the second rate: half period of 16 cycles, byte on the line
  task automatic t_tx_only();
    int low;
    low = 0;
    apb(1'b1, `OFF_XFER_CTRL, 32'h41);
    apb(1'b1, `OFF_DATA_BUF, 32'h5A);
    apb(1'b1, `OFF_XFER_CTRL, 32'h81);
    // Sampled on the falling edge, where the clock pin has settled
    repeat (200) begin
      @(negedge pclk);
      if (sck_out === 1'b0) break;
    end
    while (sck_out === 1'b0 && low < 100) begin
      @(negedge pclk);
      low++;
    end
    chk(low, 32'h10);
    wait_irq();
    chk(peer_rx, 8'h5A);
    apb(1'b1, `OFF_XFER_CTRL, 32'h01);
    wait_done();
    chk(rd, `STAT_ONES);
    apb(1'b1, `OFF_INT_CLR, 32'h3);
    apb(1'b0, `OFF_INT_STAT, 32'h0);
    chk(rd, 32'h0);
    $display("transmit only done");
  endtask : t_tx_only

  // External clock receive; idle without run freezes it first
  task automatic t_external();
    peer_tx <= 8'hC3;
    apb(1'b1, `OFF_XFER_CTRL, 32'h77);
    apb(1'b1, `OFF_XFER_CTRL, 32'hB7);
    chk(sck_oe, 1'b0);
    idle_mode <= 1'b1;
    ext_run <= 1'b1;
    repeat (130) @(posedge pclk);
    ext_run <= 1'b0;
    repeat (30) @(posedge pclk);
    chk(irq, 1'b0);
    idle_mode <= 1'b0;
    ext_run <= 1'b1;
    wait_irq();
    ext_run <= 1'b0;
    apb(1'b0, `OFF_DATA_BUF, 32'h0);
    chk(rd, 32'hC3);
    apb(1'b1, `OFF_XFER_CTRL, 32'h77);
    wait_done();
    chk(rd, `STAT_ONES);
    $display("external clock done");
  endtask : t_external

  task automatic summarize();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Whole run takes some 900 cycles
  initial begin
    #400000;
    num_errors++;
    summarize();
  end

  initial begin
    {presetn, psel, penable, pwrite, idle_mode, ext_run} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    peer_tx = 8'h00;
    num_errors = 0;
    tests_run = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_internal();
    t_tx_only();
    t_external();
    summarize();
  end
endmodule : testbench
